/* src/rmls_top.sv */
// rmls_top: 802.15.4 link sequencer with framing, auto sequences, DMA and LFSR.
// Assumes a byte-wide modem interface and a cycle-stealing RAM port.
`include "rmls_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rmls_top import rmls_pkg::*; #(
	parameter int unsigned P_RX_WARM = `RMLS_US2CYC(`RMLS_RX_WARM_US),
	parameter int unsigned P_TX_WARM = `RMLS_US2CYC(`RMLS_TX_WARM_US),
	parameter int unsigned P_TX2RX_GAP = `RMLS_US2CYC(`RMLS_TX2RX_US - `RMLS_RX_WARM_US),
	parameter int unsigned P_RX2TX_GAP = `RMLS_US2CYC(`RMLS_RX2TX_US - `RMLS_TX_WARM_US),
	parameter int unsigned P_ACK_WAIT = `RMLS_US2CYC(`RMLS_ACK_WAIT_US),
	parameter int unsigned P_RX_WIN = `RMLS_US2CYC(`RMLS_RX_WIN_US)
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic cmd_valid_in,
	input wire rmls_cmd_t cmd_in,
	input wire logic [31:0] start_time_in,
	input wire logic [19:0] slot_len_in,
	input wire logic abort_in,
	output logic cmd_ready_out,
	input wire logic [31:0] tx_base_in,
	input wire logic [31:0] rx_base_in,
	input wire logic [7:0] tx_len_in,
	input wire logic promisc_in,
	input wire logic [15:0] pan_id_in,
	input wire logic [15:0] short_addr_in,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	input wire logic tx_ready_in,
	input wire rmls_rxb_t rx_in,
	output logic radio_tx_en_out,
	output logic radio_rx_en_out,
	output logic radio_cca_out,
	input wire logic cca_done_in,
	input wire logic cca_busy_in,
	output var rmls_dma_t dma_out,
	input wire logic dma_gnt_in,
	input wire logic [7:0] dma_rdata_in,
	input wire logic seed_load_in,
	input wire logic [31:0] seed_in,
	input wire logic rand_rd_in,
	output logic [31:0] rand_out,
	output var rmls_evt_t evt_out,
	input wire rmls_evt_t evt_mask_in,
	output logic irq_out
);
	localparam int TURN_MAX_CYC = `RMLS_US2CYC(`RMLS_TURN_MAX_US);

	rmls_state_t st;
	rmls_cmd_t cmd;
	rmls_evt_t evt;
	logic [19:0] cnt, slot_cnt;
	logic [31:0] seq_timer, lfsr;
	logic slot_tick, tx_ack, expect_ack, poll_data, rx_end, rx_bad;
	logic [7:0] tidx, tx_seq, ridx, rlen, rseq, rfc0, rfc1, b1;
	logic [15:0] tcrc, rcrc, rpan, raddr;
	logic [1:0] bcnt;

	// CRC-16, reflected, zero start; a good frame leaves zero residue
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `RMLS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ==========================================================
	// Transmit byte generation
	logic [7:0] flen, pay_end, gen_byte, push_byte;
	logic need_dma, push, last_push, pop, auto_mode;
	assign flen = tx_ack ? `RMLS_ACK_LEN : tx_len_in;
	assign pay_end = 8'(flen + `RMLS_PRE_BYTES);
	assign need_dma = !tx_ack && tidx >= `RMLS_HDR_BYTES && tidx < pay_end;
	assign auto_mode = cmd.act == RMLS_ACT_AUTORX;
	always_comb begin
		gen_byte = 8'h00;
		if (tidx == `RMLS_PRE_BYTES)
			gen_byte = `RMLS_SFD;
		else if (tidx == 8'(`RMLS_PRE_BYTES + 8'h01))
			gen_byte = flen;
		else if (tidx == pay_end)
			gen_byte = tcrc[7:0];
		else if (tidx == 8'(pay_end + 8'h01))
			gen_byte = tcrc[15:8];
		else if (tidx == `RMLS_HDR_BYTES)
			gen_byte = {5'h00, `RMLS_FC_TYPE_ACK};
		else if (tidx == 8'(`RMLS_HDR_BYTES + 8'h02))
			gen_byte = rseq;
	end
	assign push_byte = need_dma ? dma_rdata_in : gen_byte;
	// Sequencer stalls while both buffer slots are full
	assign push = st == S_TX && bcnt < `RMLS_BUF_DEPTH
		&& (!need_dma || (dma_out.req && !dma_out.we && dma_gnt_in));
	assign last_push = push && tidx == 8'(pay_end + 8'h01);
	assign pop = tx_valid_out && tx_ready_in;

	// Byte index, running FCS, sequence number of outgoing frame
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tidx <= 8'h00;
			tcrc <= 16'h0000;
			tx_seq <= 8'h00;
		end else if (st != S_TX) begin
			tidx <= 8'h00;
			tcrc <= 16'h0000;
		end else if (push) begin
			tidx <= 8'(tidx + 8'h01);
			if (tidx >= `RMLS_HDR_BYTES && tidx < pay_end)
				tcrc <= crc_step(tcrc, push_byte);
			if (!tx_ack && tidx == 8'(`RMLS_HDR_BYTES + 8'h02))
				tx_seq <= push_byte;
		end
	end

	// Two-entry buffer toward the modem; head slot is the output itself
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bcnt <= 2'h0;
			b1 <= 8'h00;
			tx_byte_out <= 8'h00;
			tx_valid_out <= 1'b0;
		end else begin
			unique case ({push, pop})
				2'b10: begin
					if (bcnt == 2'h0)
						tx_byte_out <= push_byte;
					else
						b1 <= push_byte;
					bcnt <= 2'(bcnt + 2'h1);
					tx_valid_out <= 1'b1;
				end
				2'b01: begin
					tx_byte_out <= b1;
					bcnt <= 2'(bcnt - 2'h1);
					tx_valid_out <= bcnt == 2'h2;
				end
				2'b11: begin
					if (bcnt == 2'h1)
						tx_byte_out <= push_byte;
					else begin
						tx_byte_out <= b1;
						b1 <= push_byte;
					end
				end
				2'b00: ;
			endcase
		end
	end

	// ==========================================================
	// Receive capture
	logic rx_push, rx_ok, rx_is_ack, filt_ok;
	assign rx_push = st == S_RX && rx_in.valid && ridx != 8'h00;
	assign rx_ok = rcrc == 16'h0000;
	assign rx_is_ack = rfc0[2:0] == `RMLS_FC_TYPE_ACK;
	assign filt_ok = promisc_in || rfc1[3:2] != `RMLS_DST_SHORT
		|| ((rpan == pan_id_in || rpan == `RMLS_BCAST)
		&& (raddr == short_addr_in || raddr == `RMLS_BCAST));

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ridx <= 8'h00;
			rlen <= 8'h00;
			rcrc <= 16'h0000;
			{rfc0, rfc1, rseq, rpan, raddr} <= '0;
			rx_end <= 1'b0;
			rx_bad <= 1'b0;
		end else begin
			rx_end <= 1'b0;
			rx_bad <= 1'b0;
			if (st == S_RX_WAIT)
				ridx <= 8'h00;
			else if (st == S_RX && rx_in.valid) begin
				ridx <= 8'(ridx + 8'h01);
				// first byte after SFD is length
				if (ridx == 8'h00) begin
					rlen <= rx_in.data;
					rcrc <= 16'h0000;
					rx_bad <= rx_in.data < `RMLS_ACK_LEN || rx_in.data > `RMLS_MAX_LEN;
				end else begin
					rcrc <= crc_step(rcrc, rx_in.data);
					rx_end <= ridx == rlen;
					unique case (ridx)
						8'h01: rfc0 <= rx_in.data;
						8'h02: rfc1 <= rx_in.data;
						8'h03: rseq <= rx_in.data;
						8'h04: rpan[7:0] <= rx_in.data;
						8'h05: rpan[15:8] <= rx_in.data;
						8'h06: raddr[7:0] <= rx_in.data;
						8'h07: raddr[15:8] <= rx_in.data;
						default: ;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// DMA: one cycle-stealing request, held until granted
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			dma_out <= '0;
		// receive writes win, bytes are slow
		else if (rx_push)
			dma_out <= {1'b1, 1'b1, 32'(rx_base_in + 32'(ridx) - 32'h1), rx_in.data};
		else if (dma_out.req && !dma_gnt_in)
			dma_out <= dma_out;
		else if (st == S_TX && need_dma && bcnt < `RMLS_BUF_DEPTH && !dma_out.req)
			dma_out <= {1'b1, 1'b0, 32'(tx_base_in + 32'(tidx) - 32'(`RMLS_HDR_BYTES)), 8'h00};
		else
			dma_out.req <= 1'b0;
	end

	// ==========================================================
	// Sequencer timers: free timebase and slot boundary tick
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			seq_timer <= 32'h0;
			slot_cnt <= 20'h0;
			slot_tick <= 1'b0;
		end else begin
			seq_timer <= 32'(seq_timer + 32'h1);
			slot_tick <= slot_cnt == 20'h0;
			slot_cnt <= (slot_cnt == 20'h0 || slot_cnt >= slot_len_in)
				? 20'(slot_len_in - 20'h1) : 20'(slot_cnt - 20'h1);
		end
	end

	// ==========================================================
	// Sequence state machine
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= S_IDLE;
			cmd <= '0;
			cnt <= 20'h0;
			evt <= '0;
			tx_ack <= 1'b0;
			expect_ack <= 1'b0;
			poll_data <= 1'b0;
			cmd_ready_out <= 1'b0;
		end else begin
			evt <= '0;
			if (cnt != 20'h0)
				cnt <= 20'(cnt - 20'h1);
			if (abort_in && st != S_IDLE && st != S_DOWN) begin
				st <= S_DOWN;
				cnt <= 20'(`RMLS_WARM_DOWN_CYC - 1);
			end else unique case (st)
				S_IDLE: begin
					cmd_ready_out <= 1'b1;
					if (cmd_valid_in && cmd_ready_out) begin
						cmd <= cmd_in;
						cmd_ready_out <= 1'b0;
						expect_ack <= 1'b0;
						poll_data <= 1'b0;
						tx_ack <= 1'b0;
						st <= S_START;
					end
				end
				S_START: if (!cmd.timed || seq_timer == start_time_in)
					st <= S_SLOT;
				S_SLOT: if (!cmd.slotted || slot_tick) begin
					if (cmd.act == RMLS_ACT_RX || auto_mode) begin
						st <= S_RX_WARM;
						cnt <= 20'(P_RX_WARM - 1);
					end else begin
						st <= cmd.cca ? S_CCA_WARM : S_TX_WARM;
						cnt <= cmd.cca ? 20'(P_RX_WARM - 1) : 20'(P_TX_WARM - 1);
					end
				end
				S_CCA_WARM: if (cnt == 20'h0)
					st <= S_CCA;
				S_CCA: if (cca_done_in) begin
					evt.cca_busy <= cca_busy_in;
					st <= cca_busy_in ? S_DOWN : S_TX_WARM;
					cnt <= cca_busy_in ? 20'(`RMLS_WARM_DOWN_CYC - 1) : 20'(P_TX_WARM - 1);
				end
				S_TX_WARM: if (cnt == 20'h0)
					st <= S_TX;
				S_TX: if (last_push)
					st <= S_TX_DRAIN;
				S_TX_DRAIN: if (bcnt == 2'h0 && !tx_valid_out) begin
					// ack request turns round to receive
					if (tx_ack ? auto_mode : (cmd.ack_req || cmd.act == RMLS_ACT_POLL)) begin
						expect_ack <= !tx_ack;
						st <= S_TURN_RX;
						cnt <= 20'(P_TX2RX_GAP - 1);
					end else begin
						st <= S_DOWN;
						cnt <= 20'(`RMLS_WARM_DOWN_CYC - 1);
					end
				end
				S_TURN_RX: if (cnt == 20'h0) begin
					st <= S_RX_WARM;
					cnt <= 20'(P_RX_WARM - 1);
				end
				S_RX_WARM: if (cnt == 20'h0) begin
					st <= S_RX_WAIT;
					cnt <= expect_ack ? 20'(P_ACK_WAIT - 1) : 20'(P_RX_WIN - 1);
				end
				S_RX_WAIT: begin
					if (rx_in.sfd)
						st <= S_RX;
					// extended and auto receive time out only while an ack or poll data is awaited
					else if (cnt == 20'h0 && (expect_ack || poll_data
						|| !(cmd.ext_rx || auto_mode))) begin
						evt.timeout <= 1'b1;
						st <= S_DOWN;
						cnt <= 20'(`RMLS_WARM_DOWN_CYC - 1);
					end else if (cnt == 20'h0)
						cnt <= 20'h0;
				end
				S_RX: if (rx_bad) begin
					evt.crc_err <= 1'b1;
					st <= S_RX_WAIT;
				end else if (rx_end)
					st <= S_RX_DONE;
				S_RX_DONE: begin
					st <= S_RX_WAIT;
					if (!rx_ok)
						evt.crc_err <= 1'b1;
					else if (expect_ack) begin
						if (rx_is_ack && rseq == tx_seq) begin
							evt.ack_rx <= 1'b1;
							expect_ack <= 1'b0;
							if (cmd.act == RMLS_ACT_POLL && rfc0[`RMLS_FC_PEND_BIT]) begin
								poll_data <= 1'b1;
								cnt <= 20'(P_RX_WIN - 1);
							end else begin
								st <= S_DOWN;
								cnt <= 20'(`RMLS_WARM_DOWN_CYC - 1);
							end
						end
					end else if (!filt_ok)
						evt.filtered <= 1'b1;
					else begin
						evt.rx_pkt <= 1'b1;
						if (rfc0[`RMLS_FC_AREQ_BIT] && !rx_is_ack) begin
							tx_ack <= 1'b1;
							st <= S_TURN_TX;
							cnt <= 20'(P_RX2TX_GAP - 1);
						end else if (!auto_mode) begin
							st <= S_DOWN;
							cnt <= 20'(`RMLS_WARM_DOWN_CYC - 1);
						end
					end
				end
				S_TURN_TX: if (cnt == 20'h0) begin
					st <= S_TX_WARM;
					cnt <= 20'(P_TX_WARM - 1);
				end
				S_DOWN: if (cnt == 20'h0) begin
					evt.done <= 1'b1;
					st <= S_IDLE;
				end
			endcase
		end
	end

	// Radio controls follow the state, one cycle late
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			radio_tx_en_out <= 1'b0;
			radio_rx_en_out <= 1'b0;
			radio_cca_out <= 1'b0;
		end else begin
			radio_tx_en_out <= st inside {S_TX_WARM, S_TX, S_TX_DRAIN};
			radio_rx_en_out <= st inside {S_CCA_WARM, S_CCA, S_RX_WARM, S_RX_WAIT, S_RX, S_RX_DONE};
			radio_cca_out <= st == S_CCA;
		end
	end

	// events gated by mask onto request
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			evt_out <= '0;
			irq_out <= 1'b0;
		end else begin
			evt_out <= evt;
			irq_out <= |(evt & evt_mask_in);
		end
	end

	// LFSR steps every clock except when a seed loads, read samples it
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lfsr <= 32'h1;
			rand_out <= 32'h0;
		end else begin
			if (seed_load_in)
				lfsr <= (seed_in == 32'h0) ? 32'h1 : seed_in;
			else
				lfsr <= (lfsr >> 1) ^ (lfsr[0] ? `RMLS_LFSR_TAPS : 32'h0);
			if (rand_rd_in)
				rand_out <= lfsr;
		end
	end

	// ==========================================================
	// Checks
	logic in_turn;
	logic [15:0] turn_cnt;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			in_turn <= 1'b0;
			turn_cnt <= 16'h0;
		end else begin
			in_turn <= st inside {S_TURN_RX, S_TURN_TX} || (in_turn && st inside {S_RX_WARM, S_TX_WARM});
			turn_cnt <= in_turn ? 16'(turn_cnt + 16'h1) : 16'h0;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sfd_order_a: assert property (push && tidx == `RMLS_PRE_BYTES |-> push_byte == `RMLS_SFD)
		else $error("SFD not in place after preamble");
	fcs_tail_a: assert property (last_push |-> push_byte == tcrc[15:8] && tidx == 8'(flen + 8'h05))
		else $error("FCS high byte not last");
	len_first_a: assert property (st == S_RX_WAIT && rx_in.sfd && !abort_in |=> st == S_RX && ridx == 8'h00)
		else $error("Capture not started at length byte");
	ack_turn_a: assert property (st == S_TX_DRAIN && bcnt == 2'h0 && !tx_valid_out && !tx_ack
		&& cmd.ack_req && !abort_in |=> st == S_TURN_RX && expect_ack)
		else $error("No turnaround for ack reception");
	auto_ack_a: assert property (st == S_RX_DONE && rx_ok && !expect_ack && filt_ok && !abort_in
		&& rfc0[`RMLS_FC_AREQ_BIT] && !rx_is_ack |=> st == S_TURN_TX ##1 tx_ack)
		else $error("Ack not scheduled");
	tx_warm_a: assert property ($rose(st == S_TX_WARM) |-> cnt == 20'(P_TX_WARM - 1))
		else $error("Transmit warm-up length wrong");
	turn_max_a: assert property (in_turn |-> turn_cnt < 16'(TURN_MAX_CYC))
		else $error("Turnaround exceeded limit");
	promisc_a: assert property (promisc_in && st == S_RX_DONE |=> !evt.filtered)
		else $error("Filtering in promiscuous mode");
	rand_fresh_a: assert property (rand_rd_in && !seed_load_in ##1 rand_rd_in |=> rand_out != $past(rand_out))
		else $error("Random value repeated");
	cca_gate_a: assert property (st == S_CCA && cca_done_in && cca_busy_in && !abort_in
		|=> st == S_DOWN ##0 !radio_tx_en_out [*2])
		else $error("Transmit after busy channel");
	irq_mask_a: assert property (irq_out == |($past(evt) & $past(evt_mask_in)))
		else $error("Interrupt not gated by mask");
endmodule
`default_nettype wire

/* src/rmls_consts.svh */
// rmls_consts.svh: timing, framing and field constants for the link sequencer.
// Assumes a 200 MHz bus clock; cycle counts other than the warm-down count are derived from microsecond figures.
`ifndef RMLS_CONSTS_SVH
`define RMLS_CONSTS_SVH
`define RMLS_CLK_MHZ 200
`define RMLS_US2CYC(us) ((us) * `RMLS_CLK_MHZ)
`define RMLS_RX_WARM_US 72
`define RMLS_TX_WARM_US 92
`define RMLS_TURN_MAX_US 192
`define RMLS_RX2TX_US 176
`define RMLS_TX2RX_US 96
`define RMLS_ACK_WAIT_US 864
`define RMLS_RX_WIN_US 2000
`define RMLS_WARM_DOWN_CYC 16
`define RMLS_PRE_BYTES 8'h04
`define RMLS_HDR_BYTES 8'h06
`define RMLS_SFD 8'ha7
`define RMLS_ACK_LEN 8'h05
`define RMLS_MAX_LEN 8'h7f
`define RMLS_CRC_POLY 16'h8408
`define RMLS_LFSR_TAPS 32'h80200003
`define RMLS_FC_TYPE_ACK 3'h2
`define RMLS_FC_PEND_BIT 4
`define RMLS_FC_AREQ_BIT 5
`define RMLS_DST_SHORT 2'h2
`define RMLS_BCAST 16'hffff
`define RMLS_BUF_DEPTH 2'h2
`endif

/* src/rmls_pkg.sv */
// rmls_pkg: types shared by the link sequencer and its surroundings.
// Assumes the constants header is included where numbers are needed.
package rmls_pkg;
	typedef enum logic [1:0] {
		RMLS_ACT_TX = 2'b00,
		RMLS_ACT_RX = 2'b01,
		RMLS_ACT_POLL = 2'b10,
		RMLS_ACT_AUTORX = 2'b11
	} rmls_act_t;

	typedef struct packed {
		rmls_act_t act;
		logic ack_req;
		logic cca;
		logic timed;
		logic slotted;
		logic ext_rx;
	} rmls_cmd_t;

	typedef struct packed {
		logic done;
		logic ack_rx;
		logic rx_pkt;
		logic crc_err;
		logic cca_busy;
		logic timeout;
		logic filtered;
	} rmls_evt_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [7:0] wdata;
	} rmls_dma_t;

	typedef struct packed {
		logic valid;
		logic sfd;
		logic [7:0] data;
	} rmls_rxb_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_START = 4'b0001,
		S_SLOT = 4'b0010,
		S_CCA_WARM = 4'b0011,
		S_CCA = 4'b0100,
		S_TX_WARM = 4'b0101,
		S_TX = 4'b0110,
		S_TX_DRAIN = 4'b0111,
		S_TURN_RX = 4'b1000,
		S_RX_WARM = 4'b1001,
		S_RX_WAIT = 4'b1010,
		S_RX = 4'b1011,
		S_RX_DONE = 4'b1100,
		S_TURN_TX = 4'b1101,
		S_DOWN = 4'b1110
	} rmls_state_t;
endpackage

/* tb/rmls_modem_model.sv */
// rmls_modem_model: behavioural radio modem, channel sensor and RAM port.
// Assumes the bench sets stall and channel-busy controls at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rmls_modem_model import rmls_pkg::*; (
	input wire logic clk_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	input wire rmls_dma_t dma_in,
	output logic dma_gnt_out,
	output logic [7:0] dma_rdata_out,
	input wire logic radio_cca_in,
	output logic cca_done_out,
	output logic cca_busy_out,
	output var rmls_rxb_t rx_out,
	input wire logic stall_in,
	input wire logic busy_in
);
	// ==========================================
	// Storage and start values
	logic [7:0] mem [0:255];
	logic [7:0] txq [$];
	int cyc = 0;
	int dwait = 0;
	int ccnt = 0;
	initial begin
		tx_ready_out = 1'b0;
		dma_gnt_out = 1'b0;
		dma_rdata_out = 8'h00;
		cca_done_out = 1'b0;
		cca_busy_out = 1'b0;
		rx_out = '0;
	end
	// ==========================================
	// Byte capture and RAM writes at the rising edge
	always @(posedge clk_in) begin
		if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
			txq.push_back(tx_byte_in);
		if (dma_gnt_out && dma_in.we)
			mem[dma_in.addr[7:0]] <= dma_in.wdata;
	end
	// Slow answers on purpose: stalls, late grants, late channel result
	// Idle read data and busy flip so a stale value never looks valid
	always @(negedge clk_in) begin
		cyc <= cyc + 1;
		tx_ready_out <= !(stall_in && cyc[1]);
		dwait <= (dma_in.req && !dma_gnt_out) ? dwait + 1 : 0;
		dma_gnt_out <= dma_in.req && !dma_gnt_out && dwait == 2;
		dma_rdata_out <= (dma_in.req && dwait == 2) ? mem[dma_in.addr[7:0]] : ~dma_rdata_out;
		ccnt <= radio_cca_in ? ccnt + 1 : 0;
		cca_done_out <= ccnt == 5;
		cca_busy_out <= (ccnt == 5) ? busy_in : ~cca_busy_out;
	end
	task automatic send(input logic [7:0] b [$]);
		@(negedge clk_in);
		rx_out <= '{valid: 1'b0, sfd: 1'b1, data: ~rx_out.data};
		foreach (b[i]) begin
			repeat (3) begin
				@(negedge clk_in);
				rx_out <= '{valid: 1'b0, sfd: 1'b0, data: ~rx_out.data};
			end
			@(negedge clk_in);
			rx_out <= '{valid: 1'b1, sfd: 1'b0, data: b[i]};
		end
		@(negedge clk_in);
		rx_out <= '{valid: 1'b0, sfd: 1'b0, data: ~rx_out.data};
	endtask
endmodule
`default_nettype wire

/* tb/rmls_top_bench.sv */
// rmls_top_bench: self-checking bench for the link sequencer and modem model.
// Assumes shortened warm-up counts; all drive happens at the falling edge.
`include "rmls_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", nm, exp, got); end end
module rmls_top_bench import rmls_pkg::*; ;
	// ==========================================
	// Signals
	typedef logic [7:0] rmls_bq_t [$];
	localparam int TXW = 30;
	localparam int RXW = 20;
	localparam int GTR = 10;
	localparam int GRT = 15;
	localparam int ACKW = 200;
	localparam int WIN = 300;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic cmd_valid = 1'b0;
	rmls_cmd_t cmd = '0;
	logic promisc = 1'b0;
	logic seed_load = 1'b0;
	logic [31:0] seed = 32'h0;
	logic rand_rd = 1'b0;
	rmls_evt_t mask = '0;
	logic stall = 1'b0;
	logic busy = 1'b0;
	logic abort = 1'b0;
	logic [31:0] start_time = 32'h0;
	logic [7:0] tx_len = 8'h07;
	logic [15:0] pan = 16'hbeef;
	logic [15:0] own = 16'h1234;
	logic cmd_ready_out, tx_valid_out, tx_ready, radio_tx_en_out, radio_rx_en_out;
	logic radio_cca_out, cca_done, cca_busy, dma_gnt, irq_out;
	logic [7:0] tx_byte_out, dma_rdata;
	logic [31:0] rand_out;
	rmls_dma_t dma_out;
	rmls_rxb_t rx;
	rmls_evt_t evt_out;
	rmls_evt_t seen = '0;
	int compares = 0;
	int num_errors = 0;
	int irqs = 0;
	int warm = 0;
	int tmr = 0;
	always #2.5 clk_in = ~clk_in;
	// Only slot length and buffer bases are tied; start time and abort are exercised
	rmls_top #(.P_RX_WARM(RXW), .P_TX_WARM(TXW), .P_TX2RX_GAP(GTR), .P_RX2TX_GAP(GRT),
		.P_ACK_WAIT(ACKW), .P_RX_WIN(WIN)) u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .start_time_in(start_time),
		.slot_len_in(20'h40), .abort_in(abort), .cmd_ready_out(cmd_ready_out),
		.tx_base_in(32'h10), .rx_base_in(32'h40), .tx_len_in(tx_len), .promisc_in(promisc),
		.pan_id_in(pan), .short_addr_in(own), .tx_byte_out(tx_byte_out),
		.tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready), .rx_in(rx),
		.radio_tx_en_out(radio_tx_en_out), .radio_rx_en_out(radio_rx_en_out),
		.radio_cca_out(radio_cca_out), .cca_done_in(cca_done), .cca_busy_in(cca_busy),
		.dma_out(dma_out), .dma_gnt_in(dma_gnt), .dma_rdata_in(dma_rdata),
		.seed_load_in(seed_load), .seed_in(seed), .rand_rd_in(rand_rd), .rand_out(rand_out),
		.evt_out(evt_out), .evt_mask_in(mask), .irq_out(irq_out));
	rmls_modem_model u_mdl (.clk_in(clk_in), .tx_byte_in(tx_byte_out),
		.tx_valid_in(tx_valid_out), .tx_ready_out(tx_ready), .dma_in(dma_out),
		.dma_gnt_out(dma_gnt), .dma_rdata_out(dma_rdata), .radio_cca_in(radio_cca_out),
		.cca_done_out(cca_done), .cca_busy_out(cca_busy), .rx_out(rx),
		.stall_in(stall), .busy_in(busy));
	// Events, interrupts and pre-frame transmit cycles seen in one run; free cycle count
	always @(posedge clk_in) begin
		seen <= seen | evt_out;
		tmr <= tmr + 1;
		if (irq_out === 1'b1)
			irqs <= irqs + 1;
		if (radio_tx_en_out === 1'b1 && u_mdl.txq.size() == 0)
			warm <= warm + 1;
	end
	// ==========================================
	// Helpers
	function automatic rmls_bq_t air(input rmls_bq_t b);
		logic [15:0] c;
		rmls_bq_t r;
		c = 16'h0000;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ b[i][k]) ? (c >> 1) ^ `RMLS_CRC_POLY : c >> 1;
		r = {8'(b.size() + 2), b, c[7:0], c[15:8]};
		return r;
	endfunction
	function automatic rmls_bq_t onair(input rmls_bq_t b);
		rmls_bq_t r;
		r = {8'h00, 8'h00, 8'h00, 8'h00, `RMLS_SFD, air(b)};
		return r;
	endfunction
	task automatic chkq(input string nm, input rmls_bq_t e);
		`CHK(nm, e.size(), u_mdl.txq.size())
		foreach (e[i])
			if (i < u_mdl.txq.size())
				`CHK(nm, e[i], u_mdl.txq[i])
	endtask
	// Offer one command once idle, then wait a bounded time for done
	task automatic run(input rmls_cmd_t c);
		int n;
		n = 0;
		@(negedge clk_in);
		while (cmd_ready_out !== 1'b1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		seen = '0;
		irqs = 0;
		warm = 0;
		u_mdl.txq.delete();
		cmd = c;
		cmd_valid = 1'b1;
		@(negedge clk_in);
		cmd_valid = 1'b0;
		n = 0;
		while (seen.done !== 1'b1 && n < 3000) begin
			@(negedge clk_in);
			n++;
		end
		`CHK("done", 1'b1, seen.done)
	endtask
	// Answer once the receiver has had its warm-up
	task automatic listen(input rmls_bq_t b, input logic bad);
		int n;
		rmls_bq_t q;
		n = 0;
		q = air(b);
		if (bad)
			q[q.size() - 1] = ~q[q.size() - 1];
		while (radio_rx_en_out !== 1'b1 && n < 1000) begin
			@(negedge clk_in);
			n++;
		end
		repeat (RXW + 4) @(negedge clk_in);
		u_mdl.send(q);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_lfsr();
		logic [31:0] a;
		@(negedge clk_in);
		`CHK("ready", 1'b1, cmd_ready_out)
		seed = 32'h1234abcd;
		seed_load = 1'b1;
		@(negedge clk_in);
		seed_load = 1'b0;
		rand_rd = 1'b1;
		@(negedge clk_in);
		a = rand_out;
		@(negedge clk_in);
		rand_rd = 1'b0;
		`CHK("rand fresh", 1'b1, a !== rand_out && a !== 32'h0)
		$display("test lfsr finished");
	endtask
	task automatic t_tx();
		rmls_bq_t p;
		p = {8'h41, 8'h88, 8'h07, 8'h55, 8'haa};
		foreach (p[i])
			u_mdl.mem[8'h10 + i] = p[i];
		stall = 1'b1;
		mask = 7'h40;
		run('{act: RMLS_ACT_TX, default: 1'b0});
		chkq("tx frame", onair(p));
		`CHK("tx warm", 1'b1, warm >= TXW)
		`CHK("irq done", 1, irqs)
		$display("test tx finished");
	endtask
	task automatic t_rx();
		rmls_bq_t b;
		rmls_bq_t k;
		b = {8'h21, 8'h08, 8'h5a, 8'hef, 8'hbe, 8'h34, 8'h12, 8'h3c};
		k = {8'h02, 8'h00, 8'h5a};
		stall = 1'b0;
		fork
			run('{act: RMLS_ACT_RX, default: 1'b0});
			listen(b, 1'b0);
		join
		`CHK("rx pkt", 1'b1, seen.rx_pkt)
		foreach (b[i])
			`CHK("rx ram", b[i], u_mdl.mem[8'h40 + i])
		chkq("ack", onair(k));
		$display("test rx finished");
	endtask
	task automatic t_filt();
		logic [15:0] ad [4];
		int bit_no [4];
		rmls_bq_t b;
		ad = '{16'h9999, 16'h9999, 16'hffff, 16'h1234};
		bit_no = '{0, 4, 4, 3};
		for (int i = 0; i < 4; i++) begin
			promisc = (i == 1);
			b = {8'h01, 8'h08, 8'h11, 8'hef, 8'hbe, ad[i][7:0], ad[i][15:8], 8'h77};
			fork
				run('{act: RMLS_ACT_RX, default: 1'b0});
				listen(b, i == 3);
			join
			`CHK("rx event", 1'b1, seen[bit_no[i]])
		end
		promisc = 1'b0;
		$display("test filter finished");
	endtask
	task automatic t_txack();
		rmls_bq_t p;
		rmls_bq_t k;
		rmls_bq_t d;
		p = {8'h41, 8'h88, 8'h07, 8'h55, 8'haa};
		k = {8'h02, 8'h00, 8'h07};
		d = {8'h01, 8'h08, 8'h11, 8'hef, 8'hbe, 8'h34, 8'h12, 8'h77};
		busy = 1'b0;
		// Channel check also enables the receiver; answer only after transmit began
		fork
			run('{act: RMLS_ACT_TX, ack_req: 1'b1, cca: 1'b1, default: 1'b0});
			begin
				wait (radio_tx_en_out === 1'b1);
				listen(k, 1'b0);
			end
		join
		`CHK("ack seen", 1'b1, seen.ack_rx)
		`CHK("no timeout", 1'b0, seen.timeout)
		chkq("tx after cca", onair(p));
		// Poll ack with data pending, then the data frame follows
		k[0] = 8'h12;
		fork
			run('{act: RMLS_ACT_POLL, default: 1'b0});
			begin
				listen(k, 1'b0);
				repeat (8) @(negedge clk_in);
				u_mdl.send(air(d));
			end
		join
		`CHK("poll ack", 1'b1, seen.ack_rx)
		`CHK("poll data", 1'b1, seen.rx_pkt)
		$display("test tx ack finished");
	endtask
	task automatic t_busy();
		busy = 1'b1;
		mask = 7'h04;
		run('{act: RMLS_ACT_TX, cca: 1'b1, slotted: 1'b1, default: 1'b0});
		`CHK("cca busy", 1'b1, seen.cca_busy)
		`CHK("no tx", 0, u_mdl.txq.size())
		`CHK("irq busy", 1, irqs)
		$display("test busy finished");
	endtask
	// Timed auto-receive keeps listening after a frame; abort ends it
	task automatic t_auto();
		int t0;
		rmls_bq_t b;
		t0 = tmr;
		b = {8'h01, 8'h08, 8'h11, 8'hef, 8'hbe, 8'h34, 8'h12, 8'h77};
		start_time = 32'(tmr + 150);
		fork
			run('{act: RMLS_ACT_AUTORX, timed: 1'b1, default: 1'b0});
			begin
				listen(b, 1'b0);
				`CHK("timed start", 1'b1, tmr - t0 > 150)
				repeat (20) @(negedge clk_in);
				`CHK("auto rx on", 1'b1, radio_rx_en_out && seen.rx_pkt)
				abort = 1'b1;
				repeat (2) @(negedge clk_in);
				abort = 1'b0;
			end
		join
		$display("test auto finished");
	endtask
	// ==========================================
	// Sequence, watchdog and verdict
	task automatic stop_test();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		reset_n_in = 1'b1;
		t_lfsr();
		t_tx();
		t_rx();
		t_filt();
		t_txack();
		t_busy();
		t_auto();
		stop_test();
	end
	// Runs take a few thousand cycles; this bound is far beyond that
	initial begin
		#300000;
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
